// ==== itp_cpu.sv ====
// Purpose: CPU model: bus master and vector requests
// Assumes: One slave, hready is hreadyout
// Notes: Tasks called from the bench
`timescale 1ns/1ns
module itp_cpu
  import itp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire itp_vec_t vector_out,
  output itp_ahb_req_t ahb_req,
  output logic [31:0] hwdata,
  output logic vector_req
);
  int gap = 0;
  initial begin
    ahb_req = '0;
    hwdata = '0;
    vector_req = 1'b0;
  end
  task automatic xfer(input logic w, input logic [7:0] i,
      input logic [7:0] d, output logic [7:0] q);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    ahb_req <= '{1'b1, {22'h0, i, 2'b00}, 2'b10, w, 3'b010};
    do @(posedge ref_clk); while (!hready);
    ahb_req <= '0;
    hwdata <= {24'h0, d};
    do @(posedge ref_clk); while (!hready);
    q = hrdata[7:0];
    // Released data never keeps the last value
    hwdata <= ~hwdata;
  endtask
  task automatic vec(output itp_vec_t v);
    @(posedge ref_clk);
    vector_req <= 1'b1;
    @(posedge ref_clk);
    vector_req <= 1'b0;
    @(posedge ref_clk);
    v = vector_out;
  endtask
endmodule // itp_cpu

// ==== itp_pkg.sv ====
// Purpose: Types of the interrupt test unit
// Assumes: Single clock domain
// Notes: Constants live in itp_regs.svh
package itp_pkg;

  // AHB-Lite address phase
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
  } itp_ahb_req_t;

  // Vector answer to the CPU
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } itp_vec_t;

  typedef enum logic [1:0] {
    ITP_BUS_IDLE,
    ITP_BUS_WAIT
  } itp_bus_st_t;

  typedef enum logic [1:0] {
    ITP_SEL_NONE,
    ITP_SEL_CTRL,
    ITP_SEL_FORCE,
    ITP_SEL_PROMO
  } itp_sel_t;

endpackage

// ==== itp_regs.svh ====
// Purpose: Offsets, field positions, reset values of the interrupt test unit
// Assumes: Included by the top module and the bench
// Notes: Byte address of a register is four times its index
`ifndef ITP_REGS_SVH
`define ITP_REGS_SVH

// Register indexes
`define ITP_IDX_CTRL 8'h15
`define ITP_IDX_FORCE 8'h16
`define ITP_IDX_PROMO 8'h1f

// Test control fields
`define ITP_CTRL_OVR_BIT 4
`define ITP_CTRL_BANK_MSB 3

// Force banks that exist: 8 to f (vectors 0xff80 to 0xfff4)
`define ITP_BANK_FIRST 4'h8
`define ITP_BANK_TOP 4'hf
`define ITP_TOP_BANK_MASK 8'h07
`define ITP_NUM_BANKS 8
`define ITP_NUM_PERIPH 57

// Reset values
`define ITP_CTRL_RST 8'h0f
`define ITP_PROMO_RST 7'h79
`define ITP_PROMO_MAX 7'h79

// Vector addresses
`define ITP_VEC_HI 8'hff
`define ITP_VEC_EXTERNAL_NONMASKABLE_REQUEST_PIN 16'hfff4
`define ITP_VEC_IRQ 16'hfff2
`define ITP_VEC_TRAP_SW 16'hfff6
`define ITP_IDX_IRQ 6'd57
`define ITP_IDX_EXTERNAL_NONMASKABLE_REQUEST_PIN 6'd58

`endif

// ==== itp_top.sv ====
// Purpose: Test override, force banks and promotion of the interrupt unit
// Assumes: Requests and masks arrive on ref_clk from core logic
// Notes: Every bus transfer takes one wait state
`timescale 1ns/1ns
`include "itp_regs.svh"

module itp_top
  import itp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire itp_ahb_req_t ahb_req,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic special_mode,
  input wire logic cpu_i_mask,
  input wire logic cpu_x_mask,
  input wire logic [`ITP_NUM_PERIPH-1:0] periph_req,
  input wire logic irq_req,
  input wire logic external_nonmaskable_request_pin_req,
  input wire logic vector_req,
  output itp_vec_t vector_out,
  output logic int_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic bank_ok(input logic [3:0] bank);
    bank_ok = (bank >= `ITP_BANK_FIRST);
  endfunction

  function automatic logic [7:0] bank_mask(input logic [3:0] bank);
    if (!bank_ok(bank)) begin
      bank_mask = 8'h00;
    end else if (bank == `ITP_BANK_TOP) begin
      bank_mask = `ITP_TOP_BANK_MASK;
    end else begin
      bank_mask = 8'hff;
    end
  endfunction

  function automatic logic [2:0] bank_slot(input logic [3:0] bank);
    bank_slot = bank[2:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  // Reset image of the control byte
  localparam logic [7:0] CTRL_RST_B = `ITP_CTRL_RST;

  logic ovr_r;
  logic hresp_r;
  logic [3:0] bank_r;
  logic [6:0] promo_r;
  logic [7:0] force_r [0:`ITP_NUM_BANKS-1];
  itp_bus_st_t bus_st_r;
  itp_sel_t sel_r;
  logic wr_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic seen_r;
  logic [15:0] last_vec_r;
  itp_vec_t vec_r;
  logic pend_r;

  logic ovr_eff;
  logic [63:0] live;
  logic [63:0] eff;
  logic [7:0] live_bank;
  logic [7:0] force_rd;
  logic [7:0] wbyte;
  logic addr_take;
  itp_sel_t sel_nxt;
  logic ovr_wr_ok;
  logic force_wr_ok;
  logic promo_wr_ok;
  logic [5:0] promo_idx;
  logic promo_valid;
  logic i_any;
  logic [5:0] i_idx;
  logic cur_valid;
  logic [15:0] cur_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Request vectors

  // Override acts only in special modes
  assign ovr_eff = ovr_r && special_mode;

  // Live lines: pins come already sampled by core logic
  always_comb begin
    live = 64'h0;
    live[`ITP_NUM_PERIPH-1:0] = periph_req;
    live[`ITP_IDX_IRQ] = irq_req;
    live[`ITP_IDX_EXTERNAL_NONMASKABLE_REQUEST_PIN] = external_nonmaskable_request_pin_req;
  end

  // Force bits replace the live lines under override
  always_comb begin
    eff = live;
    if (ovr_eff) begin
      for (int b = 0; b < `ITP_NUM_BANKS; b++) begin
        eff[b*8 +: 8] = force_r[b];
      end
    end
  end

  always_comb begin
    live_bank = 8'h00;
    for (int b = 0; b < `ITP_NUM_BANKS; b++) begin
      if (bank_slot(bank_r) == 3'(b)) begin
        live_bank = live[b*8 +: 8];
      end
    end
  end

  // Readback of the selected force register
  always_comb begin
    if (!special_mode) begin
      force_rd = 8'h00;
    end else if (ovr_r) begin
      force_rd = force_r[bank_slot(bank_r)] & bank_mask(bank_r);
    end else begin
      force_rd = live_bank & bank_mask(bank_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign addr_take = ahb_req.hsel && ahb_req.htrans[1] && hready;

  always_comb begin
    unique case (ahb_req.haddr[9:0])
      {`ITP_IDX_CTRL, 2'b00}: sel_nxt = ITP_SEL_CTRL;
      {`ITP_IDX_FORCE, 2'b00}: sel_nxt = ITP_SEL_FORCE;
      {`ITP_IDX_PROMO, 2'b00}: sel_nxt = ITP_SEL_PROMO;
      default: sel_nxt = ITP_SEL_NONE;
    endcase
  end

  assign wbyte = hwdata[7:0];
  assign ovr_wr_ok = special_mode && cpu_i_mask && cpu_x_mask;
  assign force_wr_ok = special_mode && ovr_r && cpu_i_mask &&
                       bank_ok(bank_r);
  assign promo_wr_ok = cpu_i_mask;

  // Address phase capture, one wait state, then data
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus_st_r <= ITP_BUS_IDLE;
      sel_r <= ITP_SEL_NONE;
      wr_r <= 1'b0;
      hreadyout_r <= 1'b1;
    end else if (clk_en) begin
      unique case (bus_st_r)
        ITP_BUS_IDLE: begin
          if (addr_take) begin
            bus_st_r <= ITP_BUS_WAIT;
            sel_r <= sel_nxt;
            wr_r <= ahb_req.hwrite;
            hreadyout_r <= 1'b0;
          end
        end
        ITP_BUS_WAIT: begin
          bus_st_r <= ITP_BUS_IDLE;
          hreadyout_r <= 1'b1;
        end
      endcase
    end
  end

  // Read data loaded in the wait cycle, after any earlier write
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hrdata_r <= 32'h0;
    end else if (clk_en) begin
      if (bus_st_r == ITP_BUS_WAIT && !wr_r) begin
        unique case (sel_r)
          ITP_SEL_CTRL: hrdata_r <= {27'h0, ovr_r, bank_r};
          ITP_SEL_FORCE: hrdata_r <= {24'h0, force_rd};
          ITP_SEL_PROMO: hrdata_r <= {24'h0, promo_r, 1'b0};
          ITP_SEL_NONE: hrdata_r <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  wire wr_now = (bus_st_r == ITP_BUS_WAIT) && wr_r;

  // Bank select, written whenever addressed
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bank_r <= CTRL_RST_B[3:0];
    end else if (clk_en) begin
      if (wr_now && sel_r == ITP_SEL_CTRL) begin
        bank_r <= wbyte[`ITP_CTRL_BANK_MSB:0];
      end
    end
  end

  // Override bit, guarded by mode and both masks
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ovr_r <= CTRL_RST_B[`ITP_CTRL_OVR_BIT];
    end else if (clk_en) begin
      if (wr_now && sel_r == ITP_SEL_CTRL && ovr_wr_ok) begin
        ovr_r <= wbyte[`ITP_CTRL_OVR_BIT];
      end
    end
  end

  // Force banks; live state copied in as override sets
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int b = 0; b < `ITP_NUM_BANKS; b++) begin
        force_r[b] <= 8'h00;
      end
    end else if (clk_en) begin
      if (wr_now && sel_r == ITP_SEL_CTRL && ovr_wr_ok &&
          wbyte[`ITP_CTRL_OVR_BIT] && !ovr_r) begin
        for (int b = 0; b < `ITP_NUM_BANKS; b++) begin
          force_r[b] <= live[b*8 +: 8];
        end
      end else if (wr_now && sel_r == ITP_SEL_FORCE && force_wr_ok) begin
        force_r[bank_slot(bank_r)] <=
          wbyte & bank_mask(bank_r);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      promo_r <= `ITP_PROMO_RST;
    end else if (clk_en) begin
      if (wr_now && sel_r == ITP_SEL_PROMO && promo_wr_ok) begin
        promo_r <= wbyte[7:1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority decode

  // Promoted index; out of range falls back to IRQ
  always_comb begin
    promo_valid = promo_r[6] && (promo_r <= `ITP_PROMO_MAX);
    promo_idx = promo_valid ? promo_r[5:0] : `ITP_IDX_IRQ;
  end

  // Promoted index wins when requesting, else highest vector among maskable requests
  always_comb begin
    i_any = 1'b0;
    i_idx = 6'h0;
    for (int k = 0; k <= `ITP_IDX_IRQ; k++) begin
      if (eff[k]) begin
        i_any = 1'b1;
        i_idx = 6'(k);
      end
    end
    if (eff[promo_idx]) begin
      i_idx = promo_idx;
    end
  end

  always_comb begin
    cur_valid = 1'b0;
    cur_vec = `ITP_VEC_TRAP_SW;
    if (eff[`ITP_IDX_EXTERNAL_NONMASKABLE_REQUEST_PIN] && !cpu_x_mask) begin
      cur_valid = 1'b1;
      cur_vec = `ITP_VEC_EXTERNAL_NONMASKABLE_REQUEST_PIN;
    end else if (i_any && !cpu_i_mask) begin
      cur_valid = 1'b1;
      cur_vec = {`ITP_VEC_HI, 1'b1, i_idx, 1'b0};
    end
  end

  // Last valid request remembered for a vanished source
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      last_vec_r <= `ITP_VEC_TRAP_SW;
    end else if (clk_en) begin
      if (cur_valid) begin
        last_vec_r <= cur_vec;
      end
    end
  end

  // Sticky: some request has been valid since reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      seen_r <= 1'b0;
    end else if (clk_en) begin
      if (cur_valid) begin
        seen_r <= 1'b1;
      end
    end
  end

  // Pending flag, one cycle behind the decoder
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pend_r <= 1'b0;
    end else if (clk_en) begin
      pend_r <= cur_valid;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      vec_r <= '0;
    end else if (clk_en) begin
      vec_r.valid <= vector_req;
      if (vector_req) begin
        if (cur_valid) begin
          vec_r.addr <= cur_vec;
        end else if (seen_r) begin
          vec_r.addr <= last_vec_r;
        end else begin
          vec_r.addr <= `ITP_VEC_TRAP_SW;
        end
      end
    end
  end

  // Response flop, always OKAY
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hresp_r <= 1'b0;
    end else if (clk_en) begin
      hresp_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = hresp_r;
  assign vector_out = vec_r;
  assign int_pending = pend_r;

endmodule // itp_top

// ==== itp_top_properties.sv ====
// Purpose: Port checks of the interrupt test unit
// Assumes: One clock, sync reset
// Notes: Bound to itp_top
`timescale 1ns/1ns
module itp_props
  import itp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire itp_ahb_req_t ahb_req,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic special_mode,
  input wire logic cpu_x_mask,
  input wire logic external_nonmaskable_request_pin_req,
  input wire logic vector_req,
  input wire itp_vec_t vector_out
);
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_take;
    ahb_req.hsel && ahb_req.htrans[1] && hready && clk_en;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  AST_WAIT: assert property (s_take |=> s_wait)
    else $error("wait state wrong");
  AST_IDLE: assert property (
    hreadyout && !ahb_req.htrans[1] |=> hreadyout)
    else $error("stall without transfer");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("response not okay");
  AST_HI_ZERO: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_VEC_ANSWER: assert property (vector_req && clk_en |=> vector_out.valid)
    else $error("vector not answered");
  AST_VEC_CAUSE: assert property (vector_out.valid |-> $past(vector_req))
    else $error("vector without request");
  AST_VEC_PAGE: assert property (
    vector_out.valid |-> vector_out.addr[15:8] == 8'hff)
    else $error("vector outside page");
  AST_EXTERNAL_NONMASKABLE_REQUEST_PIN_TOP: assert property (
    vector_req && external_nonmaskable_request_pin_req && !cpu_x_mask && !special_mode |=>
    vector_out.addr == 16'hfff4)
    else $error("nonmaskable not first");
endmodule // itp_props

bind itp_top itp_props itp_props_inst (.ref_clk, .reset, .clk_en, .ahb_req,
  .hready, .hreadyout, .hrdata, .hresp, .special_mode, .cpu_x_mask,
  .external_nonmaskable_request_pin_req, .vector_req, .vector_out);

// ==== tb_interrupt_test_and_promotion_regs.sv ====
// Purpose: Self-checking bench of the interrupt test unit
// Assumes: itp_cpu drives bus and vector requests
// Notes: clk_en held high
`timescale 1ns/1ns
`include "itp_regs.svh"
module tb_interrupt_test_and_promotion_regs;
  import itp_pkg::*;
  localparam bit [7:0] CTL = `ITP_IDX_CTRL;
  localparam bit [7:0] FRC = `ITP_IDX_FORCE;
  localparam bit [7:0] PRO = `ITP_IDX_PROMO;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic special_mode = 1'b0;
  logic cpu_i_mask = 1'b1;
  logic cpu_x_mask = 1'b1;
  logic [`ITP_NUM_PERIPH-1:0] periph_req = '0;
  logic irq_req = 1'b0;
  logic external_nonmaskable_request_pin_req = 1'b0;
  logic hreadyout, hresp, vector_req, int_pending;
  logic [31:0] hrdata, hwdata;
  itp_ahb_req_t ahb_req;
  itp_vec_t vector_out;
  int error_cnt = 0;
  int n_compared = 0;
  always #25 ref_clk = ~ref_clk;
  itp_top itp_top_inst (.ref_clk, .reset, .clk_en(1'b1), .ahb_req,
    .hready(hreadyout), .hwdata, .hreadyout, .hrdata, .hresp,
    .special_mode, .cpu_i_mask, .cpu_x_mask, .periph_req, .irq_req,
    .external_nonmaskable_request_pin_req, .vector_req, .vector_out, .int_pending);
  itp_cpu itp_cpu_inst (.ref_clk, .hready(hreadyout), .hrdata,
    .vector_out, .ahb_req, .hwdata, .vector_req);
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] i, d);
    logic [7:0] q;
    itp_cpu_inst.xfer(1'b1, i, d, q);
  endtask
  task automatic rd(input logic [7:0] i, e);
    logic [7:0] q;
    itp_cpu_inst.xfer(1'b0, i, 8'h00, q);
    chk("reg", {8'h00, q}, {8'h00, e});
  endtask
  task automatic vc(input logic [15:0] e);
    itp_vec_t v;
    itp_cpu_inst.vec(v);
    chk("vec_valid", {15'h0, v.valid}, 16'h0001);
    chk("vec_addr", v.addr, e);
  endtask
  task automatic md(input logic s, i, x);
    @(posedge ref_clk);
    special_mode <= s;
    cpu_i_mask <= i;
    cpu_x_mask <= x;
  endtask
  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(CTL, 8'h0f);
    rd(PRO, 8'hf2);
    rd(FRC, 8'h00);
    rd(8'h20, 8'h00);
    chk("pending", {15'h0, int_pending}, 16'h0000);
    vc(16'hfff6);
  endtask
  task automatic t_ctrl;
    wr(CTL, 8'h17);
    rd(CTL, 8'h07);
    md(1'b1, 1'b1, 1'b0);
    wr(CTL, 8'h18);
    rd(CTL, 8'h08);
  endtask
  task automatic t_force;
    md(1'b1, 1'b1, 1'b1);
    periph_req[7:0] <= 8'ha5;
    rd(FRC, 8'ha5);
    wr(FRC, 8'h3c);
    rd(FRC, 8'ha5);
    wr(CTL, 8'h18);
    rd(CTL, 8'h18);
    periph_req[7:0] <= 8'h00;
    rd(FRC, 8'ha5);
    md(1'b1, 1'b0, 1'b1);
    wr(FRC, 8'h81);
    rd(FRC, 8'ha5);
    md(1'b1, 1'b1, 1'b1);
    wr(FRC, 8'h81);
    rd(FRC, 8'h81);
    wr(CTL, 8'h17);
    wr(FRC, 8'hff);
    rd(FRC, 8'h00);
    wr(CTL, 8'h1f);
    wr(FRC, 8'hff);
    rd(FRC, 8'h07);
    wr(FRC, 8'h01);
    irq_req <= 1'b1;
    md(1'b1, 1'b0, 1'b1);
    vc(16'hfff0);
    md(1'b0, 1'b1, 1'b1);
    rd(FRC, 8'h00);
    irq_req <= 1'b0;
  endtask
  task automatic t_promo;
    logic [7:0] sel[2] = '{8'hf4, 8'h10};
    periph_req <= {1'b1, 55'h0, 1'b1};
    md(1'b0, 1'b0, 1'b1);
    wr(PRO, 8'h80);
    rd(PRO, 8'hf2);
    md(1'b0, 1'b1, 1'b1);
    wr(PRO, 8'h80);
    rd(PRO, 8'h80);
    md(1'b0, 1'b0, 1'b1);
    vc(16'hff80);
    itp_cpu_inst.gap = 3;
    foreach (sel[k]) begin
      md(1'b0, 1'b1, 1'b1);
      wr(PRO, sel[k]);
      md(1'b0, 1'b0, 1'b1);
      vc(16'hfff0);
    end
    itp_cpu_inst.gap = 0;
    external_nonmaskable_request_pin_req <= 1'b1;
    md(1'b0, 1'b0, 1'b0);
    vc(16'hfff4);
    chk("pending", {15'h0, int_pending}, 16'h0001);
    periph_req <= '0;
    external_nonmaskable_request_pin_req <= 1'b0;
    vc(16'hfff4);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_ctrl();
    t_force();
    t_promo();
    report_and_stop();
  end
  initial begin
    repeat (4000) @(posedge ref_clk);
    error_cnt++;
    report_and_stop();
  end
endmodule // tb_interrupt_test_and_promotion_regs
